//--- hw/fsw_pkg.sv
// fsw_pkg: constants, register map and types of the flash self-write unit
// assumes one 200 MHz clock and an apb master for the registers
package fsw_pkg;
   // ==========================================================
   // register map (byte addresses)
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_KEY = 12'h004;
   localparam logic [11:0] ADDR_ADDR_LO = 12'h008;
   localparam logic [11:0] ADDR_ADDR_HI = 12'h00c;
   localparam logic [11:0] ADDR_DATA_LO = 12'h010;
   localparam logic [11:0] ADDR_DATA_HI = 12'h014;
   localparam logic [11:0] ADDR_CONFIG = 12'h018;
   // ==========================================================
   // control register fields
   localparam int CTRL_START = 1;
   localparam int CTRL_WEN = 2;
   localparam int CTRL_ERASE = 4;
   localparam int CTRL_LATCH_ONLY = 5;
   localparam int CTRL_CFG_SEL = 6;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] KEY_RESET = 8'h00;
   // config register fields: bit 0 protect_n, bits 2:1 protect size
   localparam int CFG_CP_N = 0;
   localparam int CFG_WP_LSB = 1;
   localparam logic [2:0] CONFIG_RESET = 3'h7;
   // ==========================================================
   // unlock pattern and array geometry
   localparam logic [7:0] KEY_FIRST = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'haa;
   localparam int NUM_LATCH = 32;
   localparam int WORD_W = 14;
   localparam logic [13:0] BLANK_WORD = 14'h3fff;
   localparam logic [14:0] USER_ID_BASE = 15'h0000;
   localparam int FORCED_NOPS = 2;
   // ==========================================================
   // timing: nominal array busy time
   localparam int BUSY_TIME_US = 2000;
   localparam int CLK_MHZ = 200;
   localparam int BUSY_CYCLES = BUSY_TIME_US * CLK_MHZ;
   // ==========================================================
   // types
   typedef enum logic [1:0] {
      FSW_UL_IDLE = 2'b00,
      FSW_UL_KEY1 = 2'b01,
      FSW_UL_KEY2 = 2'b11
   } fsw_unlock_t;
   typedef enum logic [1:0] {
      FSW_OP_IDLE = 2'b00,
      FSW_OP_NOP = 2'b01,
      FSW_OP_BUSY = 2'b11
   } fsw_op_t;
   typedef struct packed {
      logic req;
      logic erase;
      logic [9:0] row;
      logic [13:0] data;
   } fsw_flash_cmd_t;
endpackage

//--- hw/fsw_top.sv
// fsw_top: flash self-write sequencer with apb registers
// assumes an apb master, a cpu with stall input, and a flash array port
`timescale 1ns/100ps
`default_nettype none
module fsw_top #(
   parameter int BUSY_CYCLES = fsw_pkg::BUSY_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic irq,
   output logic cpu_nop,
   output logic cpu_stall,
   input wire logic ext_rd,
   input wire logic [14:0] ext_addr,
   input wire logic [13:0] ext_arr_data,
   output logic [13:0] ext_rd_data,
   output logic ext_blocked,
   output var fsw_pkg::fsw_flash_cmd_t flash_cmd,
   output logic [14:0] flash_word_addr,
   input wire logic flash_done,
   output logic wp_reject_q
);
   // ==========================================================
   // apb decode
   logic wr_en;
   logic rd_en;
   logic key_wr;
   logic start_wr;
   logic other_wr;
   logic armed;
   logic go;
   logic [7:0] ctrl_q;
   logic [7:0] addr_lo_q;
   logic [6:0] addr_hi_q;
   logic [7:0] data_lo_q;
   logic [5:0] data_hi_q;
   logic [2:0] config_q;
   logic [13:0] latch_q [fsw_pkg::NUM_LATCH];
   logic [14:0] word_addr;
   logic [9:0] row;
   logic [4:0] col;
   logic protected_hit;
   logic is_user_id;
   logic [14:0] wp_limit;
   fsw_pkg::fsw_op_t op_q;
   logic [1:0] nop_cnt_q;
   logic [31:0] busy_cnt_q;
   logic op_done;
   logic load_end;

   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && !penable && !pwrite;
   assign key_wr = wr_en && paddr == fsw_pkg::ADDR_KEY;
   assign start_wr = wr_en && paddr == fsw_pkg::ADDR_CTRL &&
      pwdata[fsw_pkg::CTRL_START];
   assign other_wr = wr_en && !key_wr && !start_wr;

   // ==========================================================
   // registers, one process per register
   // start bit reads back only while a taken start is still running
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_q <= fsw_pkg::CTRL_RESET;
      end else if (wr_en && paddr == fsw_pkg::ADDR_CTRL) begin
         ctrl_q <= pwdata[7:0];
         ctrl_q[fsw_pkg::CTRL_START] <= go;
      end else if (op_done || load_end) begin
         ctrl_q[fsw_pkg::CTRL_START] <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         addr_lo_q <= 8'h00;
      end else if (wr_en && paddr == fsw_pkg::ADDR_ADDR_LO) begin
         addr_lo_q <= pwdata[7:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         addr_hi_q <= 7'h00;
      end else if (wr_en && paddr == fsw_pkg::ADDR_ADDR_HI) begin
         addr_hi_q <= pwdata[6:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         data_lo_q <= 8'h00;
      end else if (wr_en && paddr == fsw_pkg::ADDR_DATA_LO) begin
         data_lo_q <= pwdata[7:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         data_hi_q <= 6'h00;
      end else if (wr_en && paddr == fsw_pkg::ADDR_DATA_HI) begin
         data_hi_q <= pwdata[5:0];
      end
   end

   // protect bits live here so the bench can play the fuse word
   always_ff @(posedge clk) begin
      if (rst) begin
         config_q <= fsw_pkg::CONFIG_RESET;
      end else if (wr_en && paddr == fsw_pkg::ADDR_CONFIG) begin
         config_q <= pwdata[2:0];
      end
   end

   // key register is not stored; reads give zero
   always_ff @(posedge clk) begin
      if (rst) begin
         prdata <= 32'h0000_0000;
      end else if (rd_en) begin
         case (paddr)
            fsw_pkg::ADDR_CTRL: prdata <= {24'h000000, ctrl_q};
            fsw_pkg::ADDR_ADDR_LO: prdata <= {24'h000000, addr_lo_q};
            fsw_pkg::ADDR_ADDR_HI: prdata <= {25'h0000000, addr_hi_q};
            fsw_pkg::ADDR_DATA_LO: prdata <= {24'h000000, data_lo_q};
            fsw_pkg::ADDR_DATA_HI: prdata <= {26'h0000000, data_hi_q};
            fsw_pkg::ADDR_CONFIG: prdata <= {29'h0000000, config_q};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   // ==========================================================
   // unlock detector
   fsw_unlock u_unlock (
      .clk(clk),
      .rst(rst),
      .key_wr(key_wr),
      .key_data(pwdata[7:0]),
      .start_wr(start_wr),
      .other_wr(other_wr),
      .irq(irq),
      .armed(armed)
   );

   // ==========================================================
   // address split and protection
   assign row = {addr_hi_q, addr_lo_q[7:5]};
   assign col = addr_lo_q[4:0];
   assign word_addr = {row, col};
   // config space select plus low address reaches the user id words
   assign is_user_id = ctrl_q[fsw_pkg::CTRL_CFG_SEL] &&
      addr_lo_q[7:2] == 6'h00 && addr_hi_q == 7'h00;
   // size codes past the table leave the whole array open
   always_comb begin
      case (config_q[fsw_pkg::CFG_WP_LSB +: 2])
         2'b00: wp_limit = 15'h0800;
         2'b01: wp_limit = 15'h0200;
         2'b10: wp_limit = 15'h0000;
         default: wp_limit = 15'h0000;
      endcase
   end
   // user ids stay writable whatever the protect size
   assign protected_hit = !is_user_id && word_addr < wp_limit;
   // only an armed start with write enable and idle unit goes
   assign go = start_wr && armed && ctrl_q[fsw_pkg::CTRL_WEN] &&
      op_q == fsw_pkg::FSW_OP_IDLE && !protected_hit;

   always_ff @(posedge clk) begin
      if (rst) begin
         wp_reject_q <= 1'b0;
      end else if (start_wr && armed) begin
         wp_reject_q <= protected_hit;
      end
   end

   // ==========================================================
   // operation sequencer
   // every non-erase start loads the addressed latch, the last word too
   logic load_word;
   assign load_word = !pwdata[fsw_pkg::CTRL_ERASE];
   // a latch load needs no array time: it retires after the forced slots
   assign load_end = op_q == fsw_pkg::FSW_OP_NOP && nop_cnt_q == 2'd0 &&
      ctrl_q[fsw_pkg::CTRL_LATCH_ONLY] && !ctrl_q[fsw_pkg::CTRL_ERASE];
   always_ff @(posedge clk) begin
      if (rst) begin
         op_q <= fsw_pkg::FSW_OP_IDLE;
         nop_cnt_q <= 2'd0;
      end else begin
         case (op_q)
            fsw_pkg::FSW_OP_IDLE: begin
               if (go) begin
                  op_q <= fsw_pkg::FSW_OP_NOP;
                  nop_cnt_q <= 2'(fsw_pkg::FORCED_NOPS - 1);
               end
            end
            fsw_pkg::FSW_OP_NOP: begin
               if (nop_cnt_q != 2'd0) begin
                  nop_cnt_q <= nop_cnt_q - 2'd1;
               end else if (ctrl_q[fsw_pkg::CTRL_LATCH_ONLY] &&
                            !ctrl_q[fsw_pkg::CTRL_ERASE]) begin
                  op_q <= fsw_pkg::FSW_OP_IDLE; // no stall
               end else begin
                  op_q <= fsw_pkg::FSW_OP_BUSY;
               end
            end
            fsw_pkg::FSW_OP_BUSY: begin
               if (op_done) begin
                  op_q <= fsw_pkg::FSW_OP_IDLE;
               end
            end
            default: op_q <= fsw_pkg::FSW_OP_IDLE;
         endcase
      end
   end
   assign cpu_nop = op_q == fsw_pkg::FSW_OP_NOP;
   assign cpu_stall = op_q == fsw_pkg::FSW_OP_BUSY;

   // array finishes on its own done or on the nominal busy time
   // counter width covers the full nominal time at the full clock
   always_ff @(posedge clk) begin
      if (rst || op_q != fsw_pkg::FSW_OP_BUSY) begin
         busy_cnt_q <= 32'd0;
      end else begin
         busy_cnt_q <= busy_cnt_q + 32'd1;
      end
   end
   assign op_done = op_q == fsw_pkg::FSW_OP_BUSY &&
      (flash_done || busy_cnt_q == 32'(BUSY_CYCLES - 1));

   // ==========================================================
   // write latches, one per column
   genvar gi;
   generate
      for (gi = 0; gi < fsw_pkg::NUM_LATCH; gi++) begin : g_latch
         always_ff @(posedge clk) begin
            if (rst || op_done) begin
               latch_q[gi] <= fsw_pkg::BLANK_WORD;
            end else if (go && load_word && 5'(gi) == col) begin
               latch_q[gi] <= {data_hi_q, data_lo_q};
            end
         end
      end
   endgenerate

   // ==========================================================
   // flash array command: streams latches of one row only
   logic [4:0] stream_q;
   always_ff @(posedge clk) begin
      if (rst || op_q != fsw_pkg::FSW_OP_BUSY) begin
         stream_q <= 5'd0;
      end else if (stream_q != 5'd31) begin
         stream_q <= stream_q + 5'd1;
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         flash_cmd <= '0;
         flash_word_addr <= 15'h0000;
      end else begin
         flash_cmd.req <= op_q == fsw_pkg::FSW_OP_BUSY && !op_done;
         // program never implies erase
         flash_cmd.erase <= ctrl_q[fsw_pkg::CTRL_ERASE];
         flash_cmd.row <= row;
         flash_cmd.data <= latch_q[stream_q];
         flash_word_addr <= {row, stream_q};
      end
   end

   // ==========================================================
   // external programmer read path; cpu path never passes here
   // cpu fetches never use this port, so protection cannot stall them
   assign ext_blocked = !config_q[fsw_pkg::CFG_CP_N];
   always_ff @(posedge clk) begin
      if (rst) begin
         ext_rd_data <= 14'h0000;
      end else if (ext_rd) begin
         ext_rd_data <= ext_blocked ? 14'h0000 : ext_arr_data;
      end
   end
endmodule // fsw_top
`default_nettype wire

//--- hw/fsw_unlock.sv
// fsw_unlock: key pattern detector for self-write starts
// assumes other_wr pulses on every register write except key and start writes, key_wr on key writes
`timescale 1ns/100ps
`default_nettype none
module fsw_unlock (
   input wire logic clk,
   input wire logic rst,
   input wire logic key_wr,
   input wire logic [7:0] key_data,
   input wire logic start_wr,
   input wire logic other_wr,
   input wire logic irq,
   output logic armed
);
   fsw_pkg::fsw_unlock_t state_q;
   // ==========================================================
   // sequence tracker
   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= fsw_pkg::FSW_UL_IDLE;
      end else if (irq || other_wr) begin
         state_q <= fsw_pkg::FSW_UL_IDLE;
      end else if (key_wr) begin
         // a wrong key anywhere restarts the pattern
         if (key_data == fsw_pkg::KEY_FIRST) begin
            state_q <= fsw_pkg::FSW_UL_KEY1;
         end else if (key_data == fsw_pkg::KEY_SECOND &&
                      state_q == fsw_pkg::FSW_UL_KEY1) begin
            state_q <= fsw_pkg::FSW_UL_KEY2;
         end else begin
            state_q <= fsw_pkg::FSW_UL_IDLE;
         end
      end else if (start_wr) begin
         state_q <= fsw_pkg::FSW_UL_IDLE; // one start per unlock
      end
   end
   assign armed = (state_q == fsw_pkg::FSW_UL_KEY2);
endmodule // fsw_unlock
`default_nettype wire

//--- sim/fsw_assertions.sv
// fsw_assertions: port checker for the flash self-write unit
// assumes it is bound into fsw_top, one clock, sync reset
`timescale 1ns/100ps
`default_nettype none
module fsw_chk (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic cpu_nop,
   input wire logic cpu_stall,
   input wire logic ext_rd,
   input wire logic [13:0] ext_arr_data,
   input wire logic [13:0] ext_rd_data,
   input wire logic ext_blocked,
   input wire fsw_pkg::fsw_flash_cmd_t flash_cmd,
   input wire logic wp_reject_q
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // ==========================================================
   // properties
   property p_blk;
      ext_rd && ext_blocked |=> ext_rd_data == 14'h0000;
   endproperty
   a_blk: assert property (p_blk)
      else $error("protected read not zero");
   property p_open;
      ext_rd && !ext_blocked |=> ext_rd_data == $past(ext_arr_data);
   endproperty
   a_open: assert property (p_open) else $error("open read wrong");
   property p_nop;
      $rose(cpu_nop) |-> cpu_nop ##1 cpu_nop ##1 !cpu_nop;
   endproperty
   a_nop: assert property (p_nop) else $error("nop slots not two");
   property p_start;
      $rose(cpu_nop) |-> $past(psel && penable && pwrite &&
         paddr == fsw_pkg::ADDR_CTRL && pwdata[1]);
   endproperty
   a_start: assert property (p_start)
      else $error("nop without start");
   property p_stall_src;
      $rose(cpu_stall) |-> $past(cpu_nop);
   endproperty
   a_stall_src: assert property (p_stall_src)
      else $error("stall early");
   // bound sized for the short busy count used in sim
   property p_stall_max;
      $rose(cpu_stall) |-> ##[1:120] !cpu_stall;
   endproperty
   a_stall_max: assert property (p_stall_max)
      else $error("stall hung");
   property p_req;
      flash_cmd.req |-> $past(cpu_stall);
   endproperty
   a_req: assert property (p_req) else $error("array cmd w/o stall");
   property p_row;
      flash_cmd.req && $past(flash_cmd.req) |-> $stable(flash_cmd.row);
   endproperty
   a_row: assert property (p_row) else $error("row moved in op");
   property p_key_rd;
      psel && !penable && !pwrite && paddr == fsw_pkg::ADDR_KEY
         |=> prdata == 32'h00000000;
   endproperty
   a_key_rd: assert property (p_key_rd) else $error("key readable");
   c_stall: cover property ($rose(cpu_stall));
   c_load: cover property ($rose(cpu_nop) ##3 !cpu_stall);
   c_wp: cover property ($rose(wp_reject_q));
endmodule // fsw_chk
bind fsw_top fsw_chk u_chk (.clk(clk), .rst(rst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .cpu_nop(cpu_nop), .cpu_stall(cpu_stall),
   .ext_rd(ext_rd), .ext_arr_data(ext_arr_data),
   .ext_rd_data(ext_rd_data), .ext_blocked(ext_blocked),
   .flash_cmd(flash_cmd), .wp_reject_q(wp_reject_q));
`default_nettype wire

//--- sim/fsw_bench.sv
// fsw_bench: self-checking bench for the flash self-write unit
// assumes fsw_top with apb registers and the flash model as partner
`timescale 1ns/100ps
`default_nettype none
module flash_self_write_unlock_bench;
   logic clk = 0;
   logic rst = 1;
   logic psel = 0;
   logic penable = 0;
   logic pwrite = 0;
   logic irq = 0;
   logic ext_rd = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata, r;
   logic pready, pslverr, cpu_nop, cpu_stall, ext_blocked, flash_done;
   logic wp_reject_q, ers;
   logic [13:0] ext_rd_data;
   logic [14:0] flash_word_addr;
   logic [9:0] row;
   fsw_pkg::fsw_flash_cmd_t flash_cmd;
   logic [13:0] seen [32];
   int fail_count = 0;
   int num_checks = 0;
   int nops, stalls;
   always #2.5 clk = ~clk;
   // short busy count keeps the run small
   fsw_top #(.BUSY_CYCLES(80)) dut (.clk(clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
      .cpu_nop(cpu_nop), .cpu_stall(cpu_stall), .ext_rd(ext_rd),
      .ext_addr(15'h0100), .ext_arr_data(14'h1234),
      .ext_rd_data(ext_rd_data), .ext_blocked(ext_blocked),
      .flash_cmd(flash_cmd), .flash_word_addr(flash_word_addr),
      .flash_done(flash_done), .wp_reject_q(wp_reject_q));
   fsw_flash_model #(.DLY(40)) partner (.clk(clk), .flash_cmd(flash_cmd),
      .flash_done(flash_done));
   always @(posedge clk) begin
      if (cpu_nop === 1'b1) nops++;
      if (cpu_stall === 1'b1) stalls++;
      if (flash_cmd.req === 1'b1) begin
         seen[flash_word_addr[4:0]] = flash_cmd.data;
         row = flash_cmd.row;
         ers = flash_cmd.erase;
      end
   end
   // ==========================================================
   // shared tasks
   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task final_report;
      $display("checks %0d errors %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      r = prdata;
      if (n == 50) begin
         fail_count++;
         final_report();
      end
   endtask
   task idle;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   // irq stays low across the keys so the sequence holds
   task go(input logic [7:0] c);
      int n;
      nops = 0;
      stalls = 0;
      xfer(1, fsw_pkg::ADDR_CTRL, {24'h0, c & 8'hfd});
      xfer(1, fsw_pkg::ADDR_KEY, 32'h55);
      xfer(1, fsw_pkg::ADDR_KEY, 32'haa);
      xfer(1, fsw_pkg::ADDR_CTRL, {24'h0, c});
      idle();
      for (n = 0; n < 300 && (n < 8 || cpu_stall !== 1'b0); n++)
         @(posedge clk);
      if (n == 300) begin
         fail_count++;
         final_report();
      end
   endtask
   task set_addr(input logic [7:0] hi, input logic [7:0] lo);
      xfer(1, fsw_pkg::ADDR_ADDR_HI, {24'h0, hi});
      xfer(1, fsw_pkg::ADDR_ADDR_LO, {24'h0, lo});
   endtask
   // ==========================================================
   // scenarios
   task t_reset;
      xfer(1, fsw_pkg::ADDR_KEY, 32'h55);
      xfer(0, fsw_pkg::ADDR_KEY, 0);
      chk(r, 0);
      xfer(0, fsw_pkg::ADDR_CTRL, 0);
      chk(r, 0);
      xfer(0, fsw_pkg::ADDR_CONFIG, 0);
      chk(r, 32'h7);
      xfer(0, 12'h0fc, 0);
      chk(r, 0);
      idle();
   endtask
   task t_program;
      set_addr(8'h10, 8'h03);
      xfer(1, fsw_pkg::ADDR_DATA_LO, 32'h5a);
      xfer(1, fsw_pkg::ADDR_DATA_HI, 32'h12);
      go(8'h26);
      chk(nops, 2);
      chk(stalls, 0);
      xfer(0, fsw_pkg::ADDR_CTRL, 0);
      chk(r, 32'h24);
      xfer(1, fsw_pkg::ADDR_ADDR_LO, 32'h04);
      go(8'h06);
      chk(stalls > 8, 1);
      chk(row, 10'h080);
      chk(seen[3], 14'h125a);
      chk(seen[4], 14'h125a);
      chk(seen[5], 14'h3fff);
      go(8'h06);
      chk(seen[3], 14'h3fff);
      chk(ers, 0);
   endtask
   task t_broken;
      nops = 0;
      xfer(1, fsw_pkg::ADDR_KEY, 32'h55);
      xfer(1, fsw_pkg::ADDR_ADDR_LO, 32'h00);
      xfer(1, fsw_pkg::ADDR_KEY, 32'haa);
      xfer(1, fsw_pkg::ADDR_CTRL, 32'h26);
      xfer(1, fsw_pkg::ADDR_KEY, 32'h55);
      idle();
      irq <= 1'b1;
      @(posedge clk);
      irq <= 1'b0;
      xfer(1, fsw_pkg::ADDR_KEY, 32'haa);
      xfer(1, fsw_pkg::ADDR_CTRL, 32'h26);
      xfer(1, fsw_pkg::ADDR_KEY, 32'haa);
      xfer(1, fsw_pkg::ADDR_KEY, 32'h55);
      xfer(1, fsw_pkg::ADDR_CTRL, 32'h26);
      xfer(0, fsw_pkg::ADDR_CTRL, 0);
      chk(r[1], 0);
      idle();
      repeat (4) @(posedge clk);
      chk(nops, 0);
   endtask
   task t_erase_uid;
      go(8'h16);
      chk(ers, 1);
      set_addr(8'h00, 8'h01);
      xfer(1, fsw_pkg::ADDR_CONFIG, 32'h1);
      go(8'h46);
      chk(stalls > 8, 1);
      chk(wp_reject_q, 0);
      chk(row, 10'h000);
   endtask
   task t_protect;
      ext_rd <= 1'b1;
      xfer(1, fsw_pkg::ADDR_CONFIG, 32'h0);
      idle();
      @(posedge clk);
      chk(ext_rd_data, 0);
      set_addr(8'h00, 8'h40);
      go(8'h06);
      chk(stalls, 0);
      chk(wp_reject_q, 1);
      xfer(1, fsw_pkg::ADDR_CONFIG, 32'h7);
      idle();
      @(posedge clk);
      chk(ext_rd_data, 14'h1234);
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_program();
      t_broken();
      t_erase_uid();
      t_protect();
      final_report();
   end
endmodule // flash_self_write_unlock_bench
`default_nettype wire

//--- sim/fsw_flash_model.sv
// fsw_flash_model: flash array stand-in answering busy commands
// assumes flash_cmd.req stays high for the whole erase or program
`timescale 1ns/100ps
`default_nettype none
module fsw_flash_model #(
   parameter int DLY = 40
) (
   input wire logic clk,
   input wire fsw_pkg::fsw_flash_cmd_t flash_cmd,
   output logic flash_done
);
   // ==========================================================
   // answer one pulse per command, never twice
   int cnt_q;
   always_ff @(posedge clk) begin
      flash_done <= flash_cmd.req && cnt_q == DLY;
      cnt_q <= flash_cmd.req ? cnt_q + 1 : 0;
   end
endmodule // fsw_flash_model
`default_nettype wire
